// >>> logic/sbrg_defs.vh
// register offsets, field positions, reset values and divide factors of the bit rate divider
`ifndef SBRG_DEFS_VH
`define SBRG_DEFS_VH

// byte addresses on the register bus
`define SBRG_OFS_TX_STATUS_CONTROL 12'h000
`define SBRG_OFS_RX_STATUS_CONTROL 12'h004
`define SBRG_OFS_RATE_CONTROL 12'h008
`define SBRG_OFS_DIVISOR_HIGH 12'h00C
`define SBRG_OFS_DIVISOR_LOW 12'h010
`define SBRG_OFS_RATE_STATUS 12'h014

// field positions
`define SBRG_BIT_SYNC_MODE 4
`define SBRG_BIT_HIGH_SPEED 2
`define SBRG_BIT_WIDE_DIVIDER 3

// writable bits per register; the rest are status of other parts and read as zero here
`define SBRG_TX_WMASK 8'hFD
`define SBRG_RX_WMASK 8'hF8
`define SBRG_RATE_WMASK 8'h1B

// reset values
`define SBRG_RST_TX 8'h00
`define SBRG_RST_RX 8'h00
`define SBRG_RST_RATE 8'h00
`define SBRG_RST_DIVISOR 8'h00

// clocks per bit tick are factor * (divisor + 1); stored as factor - 1
`define SBRG_PRE_ASYNC_SLOW8 6'h3F
`define SBRG_PRE_ASYNC_FAST8 6'h0F
`define SBRG_PRE_ASYNC_SLOW16 6'h0F
`define SBRG_PRE_ASYNC_FAST16 6'h03
`define SBRG_PRE_SYNC 6'h03

// number of receive samples in the majority vote window; two must agree
`define SBRG_VOTE_SAMPLES 3

`endif

// >>> logic/sbrg_rx_sampler.v
// receive pin synchroniser and three-sample majority detector
`include "sbrg_defs.vh"

module sbrg_rx_sampler #(
    parameter SAMPLES = `SBRG_VOTE_SAMPLES
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // control
    input wire sample_en,
    input wire clear,
    // pin and result
    input wire rx_pin,
    output reg rx_level
);
    reg sync1_q;
    reg sync2_q;
    reg [SAMPLES-1:0] samples_q;
    integer i;
    reg [1:0] ones;

    always @* begin
        ones = 2'd0;
        for (i = 0; i < SAMPLES; i = i + 1) begin
            ones = ones + {1'b0, samples_q[i]};
        end
    end

    // pin idles high, so reset fills the window with ones
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            samples_q <= {SAMPLES{1'b1}};
            rx_level <= 1'b1;
        end else begin
            sync1_q <= rx_pin;
            sync2_q <= sync1_q;
            if (clear) begin
                samples_q <= {SAMPLES{1'b1}};
            end else if (sample_en) begin
                samples_q <= {samples_q[SAMPLES-2:0], sync2_q};
            end
            rx_level <= (ones >= 2'd2);
        end
    end
endmodule

// >>> logic/sbrg_top.v
// bit rate divider with register bus slave and receive sampling
//
// Our own choices: the address map and the APB slave port.
`include "sbrg_defs.vh"

module sbrg_top (
    // clock and reset
    input wire CLK,
    input wire RST_N,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output wire PREADY,
    output wire [31:0] PRDATA,
    output wire PSLVERR,
    // serial line
    input wire RX_PIN,
    // to framing logic
    output wire BIT_TICK,
    output wire SAMPLE_TICK,
    output wire RX_LEVEL
);
    reg [7:0] tx_ctrl_q;
    reg [7:0] rx_ctrl_q;
    reg [7:0] rate_ctrl_q;
    reg [7:0] div_hi_q;
    reg [7:0] div_lo_q;
    reg pready_q;
    reg pslverr_q;
    reg [31:0] prdata_q;
    reg [15:0] div_cnt_q;
    reg [15:0] div_cnt_d;
    reg [5:0] pre_cnt_q;
    reg [5:0] pre_cnt_d;
    reg bit_tick_q;
    reg sample_tick_q;
    reg [5:0] pre_max;
    reg [7:0] rd_byte;
    reg hit;
    wire [15:0] divisor;
    wire sync_mode;
    wire high_speed;
    wire wide_div;
    wire setup_ph;
    wire wr_done;
    wire div_write;
    wire base_wrap;
    wire pre_wrap;
    wire rx_level;

    assign sync_mode = tx_ctrl_q[`SBRG_BIT_SYNC_MODE];
    assign high_speed = tx_ctrl_q[`SBRG_BIT_HIGH_SPEED];
    assign wide_div = rate_ctrl_q[`SBRG_BIT_WIDE_DIVIDER];

    // narrow divider takes no value from the high byte; a write to it still restarts the counters
    assign divisor = wide_div ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};

    // register bus: one wait-free access phase, answer registered in setup
    assign setup_ph = PSEL & ~PENABLE;
    assign wr_done = PSEL & PENABLE & pready_q & PWRITE & ~pslverr_q;
    assign div_write = wr_done & PSTRB[0] &
        ((PADDR == `SBRG_OFS_DIVISOR_HIGH) | (PADDR == `SBRG_OFS_DIVISOR_LOW));

    always @* begin
        hit = 1'b1;
        rd_byte = 8'h00;
        case (PADDR)
            `SBRG_OFS_TX_STATUS_CONTROL: begin
                rd_byte = tx_ctrl_q;
            end
            `SBRG_OFS_RX_STATUS_CONTROL: begin
                rd_byte = rx_ctrl_q;
            end
            `SBRG_OFS_RATE_CONTROL: begin
                rd_byte = rate_ctrl_q;
            end
            `SBRG_OFS_DIVISOR_HIGH: begin
                rd_byte = div_hi_q;
            end
            `SBRG_OFS_DIVISOR_LOW: begin
                rd_byte = div_lo_q;
            end
            `SBRG_OFS_RATE_STATUS: begin
                rd_byte = {5'h00, wide_div & ~sync_mode, sync_mode, rx_level};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_ph;
            if (setup_ph) begin
                pslverr_q <= ~hit;
                prdata_q <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end else if (pready_q) begin
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;

    // only the low byte lane carries register data
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_ctrl_q <= `SBRG_RST_TX;
            rx_ctrl_q <= `SBRG_RST_RX;
            rate_ctrl_q <= `SBRG_RST_RATE;
            div_hi_q <= `SBRG_RST_DIVISOR;
            div_lo_q <= `SBRG_RST_DIVISOR;
        end else if (wr_done & PSTRB[0]) begin
            case (PADDR)
                `SBRG_OFS_TX_STATUS_CONTROL: begin
                    tx_ctrl_q <= PWDATA[7:0] & `SBRG_TX_WMASK;
                end
                `SBRG_OFS_RX_STATUS_CONTROL: begin
                    rx_ctrl_q <= PWDATA[7:0] & `SBRG_RX_WMASK;
                end
                `SBRG_OFS_RATE_CONTROL: begin
                    rate_ctrl_q <= PWDATA[7:0] & `SBRG_RATE_WMASK;
                end
                `SBRG_OFS_DIVISOR_HIGH: begin
                    div_hi_q <= PWDATA[7:0];
                end
                `SBRG_OFS_DIVISOR_LOW: begin
                    div_lo_q <= PWDATA[7:0];
                end
                default: begin
                    tx_ctrl_q <= tx_ctrl_q;
                end
            endcase
        end
    end

    // divide factor from mode bits
    always @* begin
        if (sync_mode) begin
            pre_max = `SBRG_PRE_SYNC;
        end else if (wide_div) begin
            pre_max = high_speed ? `SBRG_PRE_ASYNC_FAST16 : `SBRG_PRE_ASYNC_SLOW16;
        end else begin
            pre_max = high_speed ? `SBRG_PRE_ASYNC_FAST8 : `SBRG_PRE_ASYNC_SLOW8;
        end
    end

    // divisor counter wraps every divisor+1 clocks, the factor counter counts those wraps
    assign base_wrap = (div_cnt_q >= divisor);
    assign pre_wrap = (pre_cnt_q >= pre_max);

    always @* begin
        div_cnt_d = div_cnt_q;
        pre_cnt_d = pre_cnt_q;
        if (div_write) begin
            div_cnt_d = 16'h0000;
            pre_cnt_d = 6'h00;
        end else if (base_wrap) begin
            div_cnt_d = 16'h0000;
            pre_cnt_d = pre_wrap ? 6'h00 : pre_cnt_q + 6'h01;
        end else begin
            div_cnt_d = div_cnt_q + 16'h0001;
        end
    end

    // a mode change takes effect on the fly; a factor counter above the new limit wraps next
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt_q <= 16'h0000;
            pre_cnt_q <= 6'h00;
            bit_tick_q <= 1'b0;
            sample_tick_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            pre_cnt_q <= pre_cnt_d;
            bit_tick_q <= ~div_write & base_wrap & pre_wrap;
            sample_tick_q <= ~div_write & base_wrap;
        end
    end

    assign BIT_TICK = bit_tick_q;
    assign SAMPLE_TICK = sample_tick_q;

    sbrg_rx_sampler #(
        .SAMPLES(`SBRG_VOTE_SAMPLES)
    ) u_sampler (
        .clk(CLK),
        .rst_n(RST_N),
        .sample_en(sample_tick_q),
        .clear(div_write),
        .rx_pin(RX_PIN),
        .rx_level(rx_level)
    );

    assign RX_LEVEL = rx_level;
endmodule

// >>> dv/sbrg_top_sva.sv
// port assertions for the bit rate divider
module sbrg_top_chk (
    // clock and reset
    input wire CLK,
    input wire RST_N,
    // register bus
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [3:0] PSTRB,
    input wire PREADY,
    input wire [31:0] PRDATA,
    input wire PSLVERR,
    // ticks
    input wire BIT_TICK,
    input wire SAMPLE_TICK
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence div_write;
        PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
    endsequence
    sequence div_addr;
        PADDR == 12'h00C || PADDR == 12'h010;
    endsequence
    ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
    ready_single_a: assert property (PREADY |=> !PREADY) else $error("ready held");
    ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
    err_with_ready_a: assert property (PSLVERR |-> PREADY) else $error("stray error");
    idle_rdata_a: assert property (!PREADY |-> PRDATA == 32'h0000_0000) else $error("stray data");
    tick_on_wrap_a: assert property (BIT_TICK |-> SAMPLE_TICK) else $error("tick off wrap");
    bit_tick_pulse_a: assert property (BIT_TICK |=> !BIT_TICK) else $error("tick held");
    div_restart_a: assert property (div_write ##0 div_addr |=> !BIT_TICK && !SAMPLE_TICK)
        else $error("no restart");
endmodule

bind sbrg_top sbrg_top_chk u_chk (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .BIT_TICK(BIT_TICK), .SAMPLE_TICK(SAMPLE_TICK));

// >>> dv/sbrg_line_model.sv
// remote transmitter that holds the receive line low for a set number of clocks
module sbrg_line_model (
    // clock and request
    input wire clk,
    input wire go,
    input wire [7:0] low_len,
    // line toward the device
    output wire rx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_q = 8'h00;
    always @(posedge clk) begin
        cnt_q <= go ? low_len : cnt_q - {7'h00, |cnt_q};
    end
    // mark level between frames
    assign rx = (cnt_q == 8'h00);
endmodule

// >>> dv/tb_sbrg_top.sv
// self-checking bench for the bit rate divider
module tb_sbrg_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, go = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, rd;
    logic [3:0] PSTRB = 4'hF;
    logic [7:0] low_len = 8'h00;
    logic err;
    wire PREADY, PSLVERR, BIT_TICK, SAMPLE_TICK, RX_LEVEL, RX_PIN;
    wire [31:0] PRDATA;
    int failures = 0, num_checks = 0, c;
    // tx, rate, high, low bytes per mode
    logic [31:0] cfg [6] = '{32'h0000_0102, 32'h0400_0102, 32'h0008_0102, 32'h0408_0102,
        32'h1400_0102, 32'h1008_0102};
    int per [6] = '{192, 48, 4144, 1036, 12, 1036};
    logic [7:0] msk [5] = '{8'hFD, 8'hF8, 8'h1B, 8'hFF, 8'hFF};
    always #12.5 CLK = ~CLK;
    sbrg_top u_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
        .PSLVERR(PSLVERR), .RX_PIN(RX_PIN), .BIT_TICK(BIT_TICK), .SAMPLE_TICK(SAMPLE_TICK),
        .RX_LEVEL(RX_LEVEL));
    sbrg_line_model u_line (.clk(CLK), .go(go), .low_len(low_len), .rx(RX_PIN));
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // idle edge first so psel never changes twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h00_0000, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge CLK);
            i++;
        end while (PREADY !== 1'b1 && i < 20);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            failures++;
            final_report();
        end
    endtask
    // clocks up to the next tick, sampled as seen at each edge
    task automatic tick(input logic sel, output int n);
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while ((sel ? SAMPLE_TICK : BIT_TICK) !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            failures++;
            final_report();
        end
    endtask
    task automatic glitch(input logic [7:0] len, input int exp);
        int lows;
        lows = 0;
        low_len <= len;
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        repeat (20) begin
            @(posedge CLK);
            lows += (RX_LEVEL === 1'b0);
        end
        chk("low cycles", exp, lows);
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            apb(1'b0, 12'(a * 4), 8'h00);
            chk("reset value", (a == 5) ? 1 : 0, rd);
        end
        apb(1'b0, 12'h018, 8'h00);
        chk("unmapped error", 1, err);
        for (int a = 0; a < 5; a++) begin
            apb(1'b1, 12'(a * 4), 8'hFF);
            apb(1'b0, 12'(a * 4), 8'h00);
            chk("write mask", msk[a], rd);
        end
        PSTRB <= 4'h0;
        apb(1'b1, 12'h010, 8'h55);
        PSTRB <= 4'hF;
        apb(1'b0, 12'h010, 8'h00);
        chk("strobe off", 8'hFF, rd);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h000, cfg[i][31:24]);
            apb(1'b1, 12'h008, cfg[i][23:16]);
            apb(1'b1, 12'h00C, cfg[i][15:8]);
            apb(1'b1, 12'h010, cfg[i][7:0]);
            tick(1'b0, c);
            // tick launched at the restart edge plus one period, seen one edge later
            chk("restart gap", per[i] + 1, c);
            tick(1'b0, c);
            chk("bit period", per[i], c);
            tick(1'b1, c);
            tick(1'b1, c);
            chk("sample period", cfg[i][19] ? cfg[i][15:0] + 1 : cfg[i][7:0] + 1, c);
            apb(1'b0, 12'h014, 8'h00);
            chk("rate status", {29'h0000_0000, cfg[i][19] & ~cfg[i][28], cfg[i][28], 1'b1},
                rd);
        end
        apb(1'b1, 12'h00C, 8'h00);
        apb(1'b1, 12'h010, 8'h00);
        for (int l = 1; l < 4; l++) glitch(8'(l), (l > 1) ? l : 0);
        final_report();
    end
endmodule
